// ===== sgt_pkg.sv
// shared types and constants of the dual channel safety gate
// assumes a single clock domain with asynchronous active low reset

package sgt_pkg;

    // ------------------------------------------------------------
    // interlock states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SGT_ST_WAIT_LOW = 1'b0,  // outputs off, waiting for both inputs low together
        SGT_ST_RUN = 1'b1        // outputs may follow the inputs
    } sgt_state_t;

    // ------------------------------------------------------------
    // channel pair carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic ch1;
        logic ch2;
    } sgt_chan_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam sgt_state_t SGT_RST_STATE = SGT_ST_WAIT_LOW;
    localparam sgt_chan_t SGT_RST_CHAN = 2'h0;
    localparam logic SGT_RST_BIT = 1'h0;
    localparam logic SGT_RST_LOCK = 1'h1;
    localparam int SGT_DEF_ID_W = 8;

endpackage

// ===== sgt_dual_channel_safety_gate.sv
// output logic of a coded dual channel safety switch
// assumes the safety and actuator pin inputs are asynchronous to clk (clk_en is used unsynchronised); downstream evaluates both
// safety outputs as two separate channels

`timescale 1ns/1ps

module sgt_dual_channel_safety_gate #(
    parameter int ID_W = sgt_pkg::SGT_DEF_ID_W
) (
    input wire logic clk,                  // 125 MHz system clock
    input wire logic reset_n,              // asynchronous reset, active low
    input wire logic clk_en,               // clock enable, freezes all state when low
    input wire logic safety_in_ch1,        // safety input, channel 1
    input wire logic safety_in_ch2,        // safety input, channel 2
    input wire logic actuator_present,     // actuator sensed in response range
    input wire logic [ID_W-1:0] actuator_id, // code read from the sensed actuator
    output logic safety_out_ch1,           // safety output, channel 1
    output logic safety_out_ch2,           // safety output, channel 2
    output logic actuator_status_out,      // status output, valid actuator present
    output logic actuator_taught,          // an actuator code has been learned
    output logic interlock_active          // outputs held off awaiting both inputs low
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (ID_W < 1) begin : g_bad_id_w
        $error("ID_W must be at least 1");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    sgt_pkg::sgt_chan_t in_meta;
    sgt_pkg::sgt_chan_t in_sync;
    sgt_pkg::sgt_chan_t in_prev;
    logic act_meta;
    logic act_sync;
    logic [ID_W-1:0] id_meta;
    logic [ID_W-1:0] id_sync;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_meta <= sgt_pkg::SGT_RST_CHAN;
            in_sync <= sgt_pkg::SGT_RST_CHAN;
            act_meta <= sgt_pkg::SGT_RST_BIT;
            act_sync <= sgt_pkg::SGT_RST_BIT;
            id_meta <= '0;
            id_sync <= '0;
        end else if (clk_en) begin
            in_meta <= '{ch1: safety_in_ch1, ch2: safety_in_ch2};
            in_sync <= in_meta;
            act_meta <= actuator_present;
            act_sync <= act_meta;
            id_meta <= actuator_id;
            id_sync <= id_meta;
        end
    end

    // previous synchronised input levels, for fall detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_prev <= sgt_pkg::SGT_RST_CHAN;
        end else if (clk_en) begin
            in_prev <= in_sync;
        end
    end

    // ------------------------------------------------------------
    // actuator learning
    // ------------------------------------------------------------
    logic [ID_W-1:0] learned_id;
    logic [ID_W-1:0] id_prev;
    logic id_steady;
    logic act_valid;

    // the code crosses bit by bit, so until one is learned only a code that held still is trusted
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            id_prev <= '0;
        end else if (clk_en) begin
            id_prev <= id_sync;
        end
    end

    assign id_steady = (id_sync == id_prev);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            actuator_taught <= sgt_pkg::SGT_RST_BIT;
            learned_id <= '0;
        end else if (clk_en && act_sync && id_steady && !actuator_taught) begin
            actuator_taught <= 1'h1;
            learned_id <= id_sync;
        end
    end

    // only the learned actuator counts once a code is held
    assign act_valid = act_sync
        && (actuator_taught ? id_sync == learned_id : id_steady);

    // ------------------------------------------------------------
    // plausibility and restart interlock
    // ------------------------------------------------------------
    sgt_pkg::sgt_state_t state;
    sgt_pkg::sgt_state_t next_state;
    logic fall_ch1;
    logic fall_ch2;
    logic partial_fall;
    logic both_low;

    assign fall_ch1 = in_prev.ch1 && !in_sync.ch1;
    assign fall_ch2 = in_prev.ch2 && !in_sync.ch2;
    // one channel drops while the other still stands high
    assign partial_fall = (fall_ch1 && in_sync.ch2) || (fall_ch2 && in_sync.ch1);
    assign both_low = !in_sync.ch1 && !in_sync.ch2;

    always_comb begin
        next_state = state;
        case (state)
            sgt_pkg::SGT_ST_WAIT_LOW: begin
                if (act_valid && both_low) begin
                    next_state = sgt_pkg::SGT_ST_RUN;
                end
            end
            sgt_pkg::SGT_ST_RUN: begin
                if (!act_valid) begin
                    next_state = sgt_pkg::SGT_ST_WAIT_LOW;
                end else if (partial_fall) begin
                    next_state = sgt_pkg::SGT_ST_WAIT_LOW;
                end
            end
            default: begin
                next_state = sgt_pkg::SGT_ST_WAIT_LOW;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= sgt_pkg::SGT_RST_STATE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    sgt_pkg::sgt_chan_t next_out;

    always_comb begin
        next_out = sgt_pkg::SGT_RST_CHAN;
        if (act_valid && next_state == sgt_pkg::SGT_ST_RUN) begin
            next_out = in_sync;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            safety_out_ch1 <= sgt_pkg::SGT_RST_BIT;
            safety_out_ch2 <= sgt_pkg::SGT_RST_BIT;
        end else if (clk_en) begin
            safety_out_ch1 <= next_out.ch1;
            safety_out_ch2 <= next_out.ch2;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            actuator_status_out <= sgt_pkg::SGT_RST_BIT;
            interlock_active <= sgt_pkg::SGT_RST_LOCK;
        end else if (clk_en) begin
            actuator_status_out <= act_valid;
            interlock_active <= (next_state == sgt_pkg::SGT_ST_WAIT_LOW);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_out_follow;
        @(posedge clk) disable iff (!reset_n)
        clk_en && act_valid && next_state == sgt_pkg::SGT_ST_RUN
        |=> safety_out_ch1 == $past(in_sync.ch1) && safety_out_ch2 == $past(in_sync.ch2);
    endproperty
    a_out_follow: assert property (p_out_follow)
        else $error("safety outputs do not follow inputs");

    property p_no_actuator_off;
        @(posedge clk) disable iff (!reset_n)
        clk_en && !act_valid |=> !safety_out_ch1 && !safety_out_ch2 && !actuator_status_out;
    endproperty
    a_no_actuator_off: assert property (p_no_actuator_off)
        else $error("outputs high without a valid actuator");

    property p_status_tracks;
        @(posedge clk) disable iff (!reset_n)
        clk_en |=> actuator_status_out == $past(act_valid);
    endproperty
    a_status_tracks: assert property (p_status_tracks)
        else $error("status output does not track actuator presence");

    property p_restart_lock;
        @(posedge clk) disable iff (!reset_n)
        clk_en && state == sgt_pkg::SGT_ST_WAIT_LOW && !both_low
        |=> !safety_out_ch1 && !safety_out_ch2 && state == sgt_pkg::SGT_ST_WAIT_LOW;
    endproperty
    a_restart_lock: assert property (p_restart_lock)
        else $error("restart without both inputs low");

    property p_partial_lock;
        @(posedge clk) disable iff (!reset_n)
        clk_en && state == sgt_pkg::SGT_ST_RUN && partial_fall
        |=> interlock_active && !safety_out_ch1 && !safety_out_ch2;
    endproperty
    a_partial_lock: assert property (p_partial_lock)
        else $error("single channel fall did not lock");

    property p_skew_ok;
        @(posedge clk) disable iff (!reset_n)
        clk_en && state == sgt_pkg::SGT_ST_RUN && act_valid && !fall_ch1 && !fall_ch2
        |=> state == sgt_pkg::SGT_ST_RUN;
    endproperty
    a_skew_ok: assert property (p_skew_ok)
        else $error("rising skew treated as fault");

    property p_learn_first;
        @(posedge clk) disable iff (!reset_n)
        clk_en && act_sync && id_steady && !actuator_taught
        |=> actuator_taught && learned_id == $past(id_sync);
    endproperty
    a_learn_first: assert property (p_learn_first)
        else $error("first actuator not learned");

    property p_learn_steady;
        @(posedge clk) disable iff (!reset_n)
        !actuator_taught && !id_steady |=> !actuator_taught;
    endproperty
    a_learn_steady: assert property (p_learn_steady)
        else $error("actuator code learned while changing");

    property p_learn_hold;
        @(posedge clk) disable iff (!reset_n)
        actuator_taught |=> actuator_taught && $stable(learned_id);
    endproperty
    a_learn_hold: assert property (p_learn_hold)
        else $error("learned actuator code changed");

    property p_sync_depth;
        @(posedge clk) disable iff (!reset_n)
        clk_en ##1 clk_en |=> in_sync.ch1 == $past(safety_in_ch1, 2)
            && act_sync == $past(actuator_present, 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth)
        else $error("input synchroniser depth wrong");

    c_learn: cover property (@(posedge clk) disable iff (!reset_n)
        !actuator_taught ##1 actuator_taught);
    c_partial: cover property (@(posedge clk) disable iff (!reset_n)
        clk_en && state == sgt_pkg::SGT_ST_RUN && partial_fall);
    c_restart: cover property (@(posedge clk) disable iff (!reset_n)
        state == sgt_pkg::SGT_ST_WAIT_LOW ##1 state == sgt_pkg::SGT_ST_RUN);
    c_actuator_loss: cover property (@(posedge clk) disable iff (!reset_n)
        actuator_status_out ##1 !actuator_status_out);

endmodule // sgt_dual_channel_safety_gate

// ===== sgt_eval_model.sv
// model of the downstream dual channel evaluation device
// assumes the gate's safety outputs are registered on the same clk
`timescale 1ns/1ps

module sgt_eval_model (
    input wire logic clk,                  // system clock
    input wire logic reset_n,              // asynchronous reset, active low
    input wire logic safety_out_ch1,       // gate safety output, channel 1
    input wire logic safety_out_ch2,       // gate safety output, channel 2
    output sgt_pkg::sgt_chan_t chan_seen   // per-channel view of the evaluator
);
    // ------------------------------------------------------------
    // each channel is latched on its own, never merged
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_seen <= sgt_pkg::SGT_RST_CHAN;
        end else begin
            chan_seen.ch1 <= safety_out_ch1;
            chan_seen.ch2 <= safety_out_ch2;
        end
    end
endmodule // sgt_eval_model

// ===== dual_channel_safety_gate_tb_top.sv
// self-checking bench of the dual channel safety gate
// assumes the gate settles within the six enabled edges that follow a pin change
`timescale 1ns/1ps

module dual_channel_safety_gate_tb_top;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic clk_en = 1'h1;
    logic ch1 = 1'h0;
    logic ch2 = 1'h0;
    logic pres = 1'h0;
    logic [7:0] act_id = 8'h00;
    logic out1, out2, status, taught, lock;
    sgt_pkg::sgt_chan_t chan_seen;
    logic [4:0] exp_q[$];
    logic [4:0] e;
    logic [31:0] rng = 32'h0001557d;
    logic [7:0] id_a = 8'h5a;
    logic [7:0] id_b;
    int fails = 0;
    int checks = 0;

    always #4 clk = ~clk;

    sgt_dual_channel_safety_gate #(.ID_W(8)) dut (.clk(clk), .reset_n(reset_n),
        .clk_en(clk_en), .safety_in_ch1(ch1), .safety_in_ch2(ch2),
        .actuator_present(pres), .actuator_id(act_id), .safety_out_ch1(out1),
        .safety_out_ch2(out2), .actuator_status_out(status),
        .actuator_taught(taught), .interlock_active(lock));

    sgt_eval_model eval (.clk(clk), .reset_n(reset_n), .safety_out_ch1(out1),
        .safety_out_ch2(out2), .chan_seen(chan_seen));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // e = {out1, out2, status, taught, interlock}
    task automatic step(input logic en, input logic c1, input logic c2, input logic p,
                        input logic [7:0] id, input logic [4:0] ex);
        @(posedge clk);
        clk_en <= en;
        ch1 <= c1;
        ch2 <= c2;
        pres <= p;
        act_id <= id;
        repeat (6) @(posedge clk);
        exp_q.push_back(ex);
    endtask

    // ------------------------------------------------------------
    // watcher: compares the oldest note with the settled outputs
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            checks++;
            if ({out1, out2, status, taught, lock} !== e) begin
                fails++;
                $display("[ERR] outputs exp %b got %b", e, {out1, out2, status, taught, lock});
            end
            if (e[0] == 1'h0 && chan_seen !== sgt_pkg::sgt_chan_t'(e[4:3])) begin
                fails++;
                $display("[ERR] chan_seen exp %b got %b", e[4:3], chan_seen);
            end
        end
    end

    task automatic print_verdict;
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset_n = 1'h1;
        exp_q.push_back(5'h01);
        step(1'h1, 1'h1, 1'h1, 1'h1, id_a, 5'h07);
        step(1'h1, 1'h0, 1'h0, 1'h1, id_a, 5'h06);
        step(1'h1, 1'h1, 1'h0, 1'h1, id_a, 5'h16);
        step(1'h1, 1'h1, 1'h1, 1'h1, id_a, 5'h1e);
        step(1'h1, 1'h0, 1'h0, 1'h1, id_a, 5'h06);
        step(1'h1, 1'h0, 1'h1, 1'h1, id_a, 5'h0e);
        step(1'h1, 1'h1, 1'h1, 1'h1, id_a, 5'h1e);
        step(1'h1, 1'h0, 1'h1, 1'h1, id_a, 5'h07);
        step(1'h1, 1'h1, 1'h1, 1'h1, id_a, 5'h07);
        step(1'h1, 1'h1, 1'h0, 1'h1, id_a, 5'h07);
        step(1'h1, 1'h0, 1'h0, 1'h1, id_a, 5'h06);
        step(1'h1, 1'h1, 1'h1, 1'h1, id_a, 5'h1e);
        step(1'h0, 1'h0, 1'h0, 1'h0, id_a, 5'h1e);
        step(1'h1, 1'h0, 1'h0, 1'h0, id_a, 5'h03);
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            id_b = (rng[9:2] == id_a) ? ~id_a : rng[9:2];
            step(1'h1, rng[0], rng[1], 1'h0, rng[17:10], 5'h03);
            step(1'h1, rng[0], rng[1], 1'h1, id_b, 5'h03);
        end
        step(1'h1, 1'h0, 1'h0, 1'h1, id_a, 5'h06);
        step(1'h1, 1'h0, 1'h0, 1'h0, id_b, 5'h03);
        // a mid-run reset forgets the learned code, so another actuator is taught
        repeat (2) @(negedge clk);
        reset_n = 1'h0;
        @(posedge clk);
        exp_q.push_back(5'h01);
        @(negedge clk);
        reset_n = 1'h1;
        step(1'h1, 1'h0, 1'h0, 1'h1, id_b, 5'h06);
        step(1'h1, 1'h0, 1'h0, 1'h1, id_a, 5'h03);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
            @(posedge clk);
        end
        if (exp_q.size() > 0) begin
            fails++;
            $display("[ERR] queue exp 0 got %0d", exp_q.size());
        end
        print_verdict();
    end
endmodule // dual_channel_safety_gate_tb_top
